// >>> common/ssi_defines.vh
// Register map, field positions, reset values and timing for the card link
`ifndef SSI_DEFINES_VH
`define SSI_DEFINES_VH

`define SSI_ADDR_MODE 32'hFFFFFE80
`define SSI_ADDR_BRR 32'hFFFFFE82
`define SSI_ADDR_CTRL 32'hFFFFFE84
`define SSI_ADDR_TDR 32'h0FFFFE86
`define SSI_ADDR_FLAGS 32'hFFFFFE88
`define SSI_ADDR_RDR 32'hFFFFFE8A
`define SSI_ADDR_CMS 32'h0FFFFE8C

`define SSI_MODE_GAP 7
`define SSI_MODE_ODD 4
`define SSI_CTRL_TIE 7
`define SSI_CTRL_RIE 6
`define SSI_CTRL_TE 5
`define SSI_CTRL_RE 4
`define SSI_CTRL_CLKLVL 1
`define SSI_CTRL_CLKOE 0
`define SSI_FLG_TX_EMPTY_FLAG 7
`define SSI_FLG_RX_FULL_FLAG 6
`define SSI_FLG_OVERRUN_FLAG 5
`define SSI_FLG_ERS 4
`define SSI_FLG_PER 3
`define SSI_FLG_TRANSMIT_END_FLAG 2
`define SSI_CMS_DIR 3
`define SSI_CMS_INV 2
`define SSI_CMS_EN 0

`define SSI_RST_MODE 8'h00
`define SSI_RST_BRR 8'hFF
`define SSI_RST_CTRL 8'h00
`define SSI_RST_TDR 8'h00
`define SSI_RST_CMS 8'h00

// One etu is this many base clocks; bits are latched on the 186th
`define SSI_ETU_TICKS 372
`define SSI_ETU_LAST 9'h173
`define SSI_SAMPLE_TICK 9'h0B9
`define SSI_HALF_TICK 9'h0B9
// Frame positions in whole etu from the start edge
`define SSI_PAR_IDX 4'h9
`define SSI_ERRSMP_IDX 4'hA
`define SSI_ERRSIG_IDX 4'hA
`define SSI_ERREND_IDX 4'hB
`define SSI_TRANSMIT_END_FLAG_GAP_IDX 4'hB
`define SSI_TRANSMIT_END_FLAG_NORM_IDX 4'hC
`define SSI_TX_END_IDX 4'hC

`endif

// >>> logic/ssi_top.v
// Smart card serial unit: registers, baud generator, T=0 transmit and receive
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "ssi_defines.vh"

module ssi_top (
  input wire ref_clk,            // 200 MHz peripheral clock
  input wire nrst,               // Asynchronous reset, active low
  input wire [31:0] reg_addr,    // Register byte address
  input wire [7:0] reg_wdata,    // Write data
  input wire reg_wr,             // Write strobe
  input wire reg_rd,             // Read strobe
  output reg [7:0] reg_rdata_r,  // Read data, cycle after strobe
  input wire data_in,            // Card data line level
  output reg data_out_r,         // Card data line drive value
  output reg data_oe_r,          // Card data line drive enable
  input wire port_direction_bit, // Port mode: clock pin direction
  input wire port_value_bit,     // Port mode: clock pin value
  output reg card_clk_out_r,     // Card clock pin value
  output reg card_clk_oe_r       // Card clock pin enable
);

  reg [7:0] mode_r;
  reg [7:0] brr_r;
  reg [7:0] ctrl_r;
  reg [7:0] tdr_r;
  reg [7:0] rdr_r;
  reg [7:0] cms_r;
  reg tx_empty_flag_r;
  reg rx_full_flag_r;
  reg overrun_flag_r;
  reg ers_r;
  reg per_r;
  reg transmit_end_flag_r;

  reg [5:0] pre_cnt_r;
  reg [7:0] div_cnt_r;
  reg clk_phase_r;
  reg base_tick_r;

  reg tx_run_r;
  reg [3:0] tx_idx_r;
  reg [8:0] tx_cnt_r;
  reg [8:0] tx_frame_r;
  reg tx_err_r;

  reg rx_run_r;
  reg [3:0] rx_idx_r;
  reg [8:0] rx_cnt_r;
  reg [7:0] rx_sr_r;
  reg rx_perr_r;
  reg rx_drive_r;
  reg line_prev_r;

  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rev8[i] = v[7 - i];
      end
    end
  endfunction

  wire card_mode_enable = cms_r[`SSI_CMS_EN];
  wire dir = cms_r[`SSI_CMS_DIR];
  wire inv = cms_r[`SSI_CMS_INV];
  wire odd = mode_r[`SSI_MODE_ODD];
  wire gap = mode_r[`SSI_MODE_GAP];
  wire te = ctrl_r[`SSI_CTRL_TE];
  wire re = ctrl_r[`SSI_CTRL_RE];
  wire clk_oe = ctrl_r[`SSI_CTRL_CLKOE];
  wire clk_lvl = ctrl_r[`SSI_CTRL_CLKLVL];

  wire wr_mode = reg_wr && (reg_addr == `SSI_ADDR_MODE);
  wire wr_brr = reg_wr && (reg_addr == `SSI_ADDR_BRR);
  wire wr_ctrl = reg_wr && (reg_addr == `SSI_ADDR_CTRL);
  wire wr_tdr = reg_wr && (reg_addr == `SSI_ADDR_TDR);
  wire wr_flags = reg_wr && (reg_addr == `SSI_ADDR_FLAGS);
  wire wr_cms = reg_wr && (reg_addr == `SSI_ADDR_CMS);

  // Own drive folded in so tx and rx see one line with no card fitted
  wire line_w = data_in & ~data_oe_r;

  // Base clock divider; no external clock path exists
  reg [5:0] pre_last;
  always @* begin
    case (mode_r[1:0])
      2'h0: pre_last = 6'h00;
      2'h1: pre_last = 6'h03;
      2'h2: pre_last = 6'h0F;
      2'h3: pre_last = 6'h3F;
      default: pre_last = 6'h00;
    endcase
  end

  // Half base period is 4^n*(N+1) clocks, so one etu is
  // 1488*2^(2n-1)*(N+1) clocks. Runs free to keep duty fixed.
  wire pre_done = (pre_cnt_r == pre_last);
  wire half_done = pre_done && (div_cnt_r == brr_r);
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_r <= 6'h00;
      div_cnt_r <= 8'h00;
      clk_phase_r <= 1'b0;
      base_tick_r <= 1'b0;
    end else begin
      base_tick_r <= half_done && !clk_phase_r;
      if (pre_done) begin
        pre_cnt_r <= 6'h00;
        if (half_done) begin
          div_cnt_r <= 8'h00;
          clk_phase_r <= ~clk_phase_r;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end else begin
        pre_cnt_r <= pre_cnt_r + 6'h01;
      end
    end
  end
  wire tick = base_tick_r;

  // Transmit side
  wire [7:0] tx_ord = dir ? rev8(tdr_r) : tdr_r;
  wire [7:0] tx_line = inv ? ~tx_ord : tx_ord;
  wire tx_par = ^tx_line ^ odd;
  wire tx_start = card_mode_enable && te && !tx_run_r && !tx_empty_flag_r;
  wire tx_last = tick && (tx_cnt_r == `SSI_ETU_LAST);
  wire tx_in_frame = (tx_idx_r <= `SSI_PAR_IDX);
  wire [3:0] tx_sel = tx_idx_r - 4'h1;
  wire tx_bit = (tx_idx_r == 4'h0) ? 1'b0 : tx_frame_r[tx_sel];
  wire tx_low = tx_run_r && tx_in_frame && !tx_bit;
  wire tx_err_smp = tx_run_r && tx_last &&
                    (tx_idx_r == `SSI_ERRSMP_IDX);
  wire tx_err_ev = tx_err_smp && !line_w;
  wire tx_transmit_end_flag_gap = (tx_idx_r == `SSI_TRANSMIT_END_FLAG_GAP_IDX) &&
                     (tx_cnt_r == 9'h000);
  wire tx_transmit_end_flag_norm = (tx_idx_r == `SSI_TRANSMIT_END_FLAG_NORM_IDX) &&
                      (tx_cnt_r == `SSI_HALF_TICK);
  wire tx_transmit_end_flag_ev = tx_run_r && tick && !tx_err_r && tx_empty_flag_r && !ers_r &&
                    (gap ? tx_transmit_end_flag_gap : tx_transmit_end_flag_norm);
  wire tx_end = tx_run_r && tx_last && (tx_idx_r == `SSI_TX_END_IDX);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_run_r <= 1'b0;
      tx_idx_r <= 4'h0;
      tx_cnt_r <= 9'h000;
      tx_frame_r <= 9'h1FF;
      tx_err_r <= 1'b0;
    end else if (!card_mode_enable || !te) begin
      tx_run_r <= 1'b0;
      tx_err_r <= 1'b0;
    end else if (tx_start) begin
      tx_run_r <= 1'b1;
      tx_idx_r <= 4'h0;
      tx_cnt_r <= 9'h000;
      tx_frame_r <= {tx_par, tx_line};
      tx_err_r <= 1'b0;
    end else if (tx_run_r && tick) begin
      if (tx_err_ev) begin
        tx_err_r <= 1'b1;
      end
      if (tx_end) begin
        // Error sampled at 11 etu, restart at 13: 2 etu later
        tx_idx_r <= 4'h0;
        tx_cnt_r <= 9'h000;
        tx_run_r <= tx_err_r;
        tx_err_r <= 1'b0;
      end else if (tx_cnt_r == `SSI_ETU_LAST) begin
        tx_cnt_r <= 9'h000;
        tx_idx_r <= tx_idx_r + 4'h1;
      end else begin
        tx_cnt_r <= tx_cnt_r + 9'h001;
      end
    end
  end

  // Receive side
  wire rx_start = card_mode_enable && re && !rx_run_r && line_prev_r && !line_w;
  wire rx_mid = rx_run_r && tick && (rx_cnt_r == `SSI_SAMPLE_TICK);
  wire [7:0] rx_ord = dir ? rev8(rx_sr_r) : rx_sr_r;
  wire [7:0] rx_byte = inv ? ~rx_ord : rx_ord;
  wire rx_perr_now = ^rx_sr_r ^ line_w ^ odd;
  wire rx_done = rx_mid && (rx_idx_r == `SSI_PAR_IDX);
  wire rx_ok_ev = rx_done && !rx_perr_now && !rx_full_flag_r;
  wire rx_over_ev = rx_done && rx_full_flag_r;
  wire rx_perr_ev = rx_done && rx_perr_now;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      line_prev_r <= 1'b1;
      rx_run_r <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_cnt_r <= 9'h000;
      rx_sr_r <= 8'h00;
      rx_perr_r <= 1'b0;
      rx_drive_r <= 1'b0;
    end else begin
      line_prev_r <= line_w;
      if (!card_mode_enable || !re) begin
        rx_run_r <= 1'b0;
        rx_drive_r <= 1'b0;
      end else if (rx_start) begin
        rx_run_r <= 1'b1;
        rx_idx_r <= 4'h0;
        rx_cnt_r <= 9'h000;
        rx_perr_r <= 1'b0;
      end else if (rx_run_r && tick) begin
        if (rx_cnt_r == `SSI_ETU_LAST) begin
          rx_cnt_r <= 9'h000;
          rx_idx_r <= rx_idx_r + 4'h1;
        end else begin
          rx_cnt_r <= rx_cnt_r + 9'h001;
        end
        if (rx_mid) begin
          case (rx_idx_r)
            4'h0: rx_run_r <= !line_w; // A high start is a glitch
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
              rx_sr_r <= {line_w, rx_sr_r[7:1]};
            end
            `SSI_PAR_IDX: rx_perr_r <= rx_perr_now;
            `SSI_ERRSIG_IDX: rx_drive_r <= rx_perr_r;
            `SSI_ERREND_IDX: begin
              rx_drive_r <= 1'b0;
              rx_run_r <= 1'b0;
            end
            default: rx_run_r <= 1'b0;
          endcase
        end
      end
    end
  end

  // Pins: open drain data, released unless a bit or error is low
  wire data_oe_nxt = card_mode_enable && (tx_low || rx_drive_r);
  reg clk_out_nxt;
  reg clk_oe_nxt;
  always @* begin
    if (card_mode_enable && clk_oe) begin
      clk_out_nxt = clk_phase_r;
      clk_oe_nxt = 1'b1;
    end else if (card_mode_enable && gap) begin
      clk_out_nxt = clk_lvl;
      clk_oe_nxt = 1'b1;
    end else begin
      clk_out_nxt = port_value_bit;
      clk_oe_nxt = port_direction_bit;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      data_out_r <= 1'b0;
      data_oe_r <= 1'b0;
      card_clk_out_r <= 1'b0;
      card_clk_oe_r <= 1'b0;
    end else begin
      data_out_r <= 1'b0;
      data_oe_r <= data_oe_nxt;
      card_clk_out_r <= clk_out_nxt;
      card_clk_oe_r <= clk_oe_nxt;
    end
  end

  // Configuration registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= `SSI_RST_MODE;
      brr_r <= `SSI_RST_BRR;
      ctrl_r <= `SSI_RST_CTRL;
      tdr_r <= `SSI_RST_TDR;
      cms_r <= `SSI_RST_CMS;
      rdr_r <= 8'h00;
    end else begin
      if (wr_mode) begin
        mode_r <= reg_wdata;
      end
      if (wr_brr) begin
        brr_r <= reg_wdata;
      end
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata;
      end
      if (wr_tdr) begin
        tdr_r <= reg_wdata;
      end
      if (wr_cms) begin
        cms_r <= reg_wdata & 8'h0D;
      end
      // Data lands even with a parity error; overrun keeps old byte
      if (rx_done && !rx_full_flag_r) begin
        rdr_r <= rx_byte;
      end
    end
  end

  // Status flags: writing 0 clears all but the end flag, a hardware set in the same cycle wins
  wire clr_tx_empty_flag = wr_flags && !reg_wdata[`SSI_FLG_TX_EMPTY_FLAG];
  wire clr_rx_full_flag = wr_flags && !reg_wdata[`SSI_FLG_RX_FULL_FLAG];
  wire clr_overrun_flag = wr_flags && !reg_wdata[`SSI_FLG_OVERRUN_FLAG];
  wire clr_ers = wr_flags && !reg_wdata[`SSI_FLG_ERS];
  wire clr_per = wr_flags && !reg_wdata[`SSI_FLG_PER];
  wire transmit_end_flag_idle = !te && !ers_r;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_empty_flag_r <= 1'b1;
      rx_full_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      ers_r <= 1'b0;
      per_r <= 1'b0;
      transmit_end_flag_r <= 1'b1;
    end else begin
      tx_empty_flag_r <= tx_start || (tx_empty_flag_r && !clr_tx_empty_flag);
      rx_full_flag_r <= rx_ok_ev || (rx_full_flag_r && !clr_rx_full_flag);
      overrun_flag_r <= rx_over_ev || (overrun_flag_r && !clr_overrun_flag);
      ers_r <= tx_err_ev || (ers_r && !clr_ers);
      per_r <= rx_perr_ev || (per_r && !clr_per);
      transmit_end_flag_r <= tx_transmit_end_flag_ev || transmit_end_flag_idle ||
                (transmit_end_flag_r && !clr_tx_empty_flag && !wr_tdr);
    end
  end

  // Read port: data stands the cycle after the strobe, else zero
  reg [7:0] rd_mux;
  always @* begin
    case (reg_addr)
      `SSI_ADDR_MODE: rd_mux = mode_r;
      `SSI_ADDR_BRR: rd_mux = brr_r;
      `SSI_ADDR_CTRL: rd_mux = ctrl_r;
      `SSI_ADDR_TDR: rd_mux = tdr_r;
      `SSI_ADDR_FLAGS: rd_mux = {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, ers_r, per_r,
                                 transmit_end_flag_r, 2'h0};
      `SSI_ADDR_RDR: rd_mux = rdr_r;
      `SSI_ADDR_CMS: rd_mux = cms_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule

// >>> dv/ssi_chk.sv
// Port checks for the smart card serial unit
`timescale 1ns/1ps
`include "ssi_defines.vh"
module ssi_chk (
  input wire ref_clk, // Clock
  input wire nrst, // Reset
  input wire [31:0] reg_addr, // Address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write
  input wire reg_rd, // Read
  input wire [7:0] reg_rdata_r, // Read data
  input wire data_oe_r, // Line enable
  input wire data_out_r, // Line value
  input wire port_direction_bit, // Port enable
  input wire port_value_bit, // Port value
  input wire card_clk_out_r, // Clock pin
  input wire card_clk_oe_r // Clock enable
);
  reg [7:0] mode_r, brr_r, ctrl_r, cms_r;
  reg [24:0] run_r;
  reg [15:0] hold_r;
  reg last_r;
  // Shadow settings so timing limits follow what software chose
  wire [15:0] tick = {7'h00, {1'b0, brr_r} + 9'h001} << {mode_r[1:0], 1'b1};
  wire [24:0] etu = 25'h174 * tick;
  wire card_mode_enable = cms_r[0];
  wire clk_on = card_mode_enable & ctrl_r[0];
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= 8'h00;
      brr_r <= 8'hFF;
      ctrl_r <= 8'h00;
      cms_r <= 8'h00;
      run_r <= 25'h0;
      hold_r <= 16'h0;
      last_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `SSI_ADDR_MODE) mode_r <= reg_wdata;
      if (reg_wr && reg_addr == `SSI_ADDR_BRR) brr_r <= reg_wdata;
      if (reg_wr && reg_addr == `SSI_ADDR_CTRL) ctrl_r <= reg_wdata;
      if (reg_wr && reg_addr == `SSI_ADDR_CMS) cms_r <= reg_wdata & 8'h0D;
      run_r <= data_oe_r ? run_r + 25'h1 : 25'h0;
      // Skip the enable latency so only the running divider is timed
      if ($past(clk_on, 3) && clk_on && card_clk_out_r == last_r)
        hold_r <= hold_r + 16'h1;
      else
        hold_r <= 16'h0;
      last_r <= card_clk_out_r;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_open_drain:
    assert property (data_oe_r |-> !data_out_r) else $error("line driven high");
  chk_divisor_read:
    assert property (reg_rd && reg_addr == `SSI_ADDR_BRR |=>
      reg_rdata_r == $past(brr_r)) else $error("divisor readback");
  chk_clk_port:
    assert property ($past(nrst) && !$past(card_mode_enable) |->
      card_clk_oe_r == $past(port_direction_bit) &&
      card_clk_out_r == $past(port_value_bit)) else $error("port pin");
  chk_clk_level:
    assert property ($past(card_mode_enable & mode_r[7] & ~ctrl_r[0]) |->
      card_clk_oe_r && card_clk_out_r == $past(ctrl_r[1]))
      else $error("level pin");
  chk_clk_enable:
    assert property ($past(clk_on) |-> card_clk_oe_r)
      else $error("clk enable");
  chk_clk_rate:
    assert property (clk_on |-> hold_r < {1'b0, tick[15:1]})
      else $error("clk too slow");
  chk_err_pulse:
    assert property ($fell(data_oe_r) && !ctrl_r[5] |-> run_r == etu)
      else $error("error pulse length");
  chk_mode_release:
    assert property (!$past(card_mode_enable, 2) && !$past(card_mode_enable) |-> !data_oe_r)
      else $error("line driven off mode");
endmodule

bind ssi_top ssi_chk u_chk (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_r, .data_oe_r, .data_out_r, .port_direction_bit,
  .port_value_bit, .card_clk_out_r, .card_clk_oe_r);

// >>> dv/ssi_card.sv
// Behavioural card on the shared, pulled-up data line
`timescale 1ns/1ps
module ssi_card #(parameter int ETU = 744) (
  input wire ref_clk, // Clock
  input wire line, // Resolved line level
  input wire err_req, // Reject frames from the device
  output reg drv_low // Pulls the line low
);
  reg [8:0] rx_bits = 9'h000;
  reg sending = 1'b0;
  reg err_seen = 1'b0;
  int n_frames = 0;
  initial drv_low = 1'b0;
  always begin
    @(negedge line);
    if (!sending) begin
      repeat (ETU / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (ETU) @(posedge ref_clk);
        rx_bits[i] = line;
      end
      n_frames++;
      repeat (ETU) @(posedge ref_clk);
      if (err_req) begin
        drv_low <= 1'b1;
        repeat (ETU) @(posedge ref_clk);
        drv_low <= 1'b0;
      end
    end
  end
  task automatic send(input [8:0] b);
    sending = 1'b1;
    @(posedge ref_clk);
    drv_low <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      repeat (ETU) @(posedge ref_clk);
      drv_low <= !b[i];
    end
    repeat (ETU) @(posedge ref_clk);
    drv_low <= 1'b0;
    repeat (ETU) @(posedge ref_clk);
    err_seen = !line;
    repeat (2 * ETU) @(posedge ref_clk);
    sending = 1'b0;
  endtask
endmodule

// >>> dv/smart_card_serial_interface_bench.sv
// Self-checking bench for the smart card serial unit
`timescale 1ns/1ps
`include "ssi_defines.vh"
`define CHECK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module smart_card_serial_interface_bench;
  localparam int ETU = 744;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg [31:0] reg_addr = 32'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg port_direction_bit = 1'b0;
  reg port_value_bit = 1'b0;
  reg err_req = 1'b0;
  reg [7:0] rd_v;
  reg clk_was;
  int n_edges = 0;
  wire [7:0] reg_rdata_r;
  wire data_out_r, data_oe_r, card_low, card_clk_out_r, card_clk_oe_r;
  wire line = !(data_oe_r && !data_out_r) && !card_low;
  int n_mismatch = 0;
  int n_compared = 0;
  always #2.5 ref_clk = ~ref_clk;
  ssi_top DUT (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .data_in(line), .data_out_r, .data_oe_r,
    .port_direction_bit, .port_value_bit, .card_clk_out_r, .card_clk_oe_r);
  ssi_card card (.ref_clk, .line, .err_req, .drv_low(card_low));
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input [31:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input [31:0] a, input [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata_r;
    @(posedge ref_clk);
    `CHECK(rd_v, e)
  endtask
  task automatic wait_flag(input int b);
    for (int i = 0; i < 20000; i++) begin
      reg_addr <= `SSI_ADDR_FLAGS;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata_r;
      @(posedge ref_clk);
      if (rd_v[b] === 1'b1) return;
    end
    n_mismatch++;
    wrap_up();
  endtask
  // Load the holding byte, then clearing the empty flag starts the frame
  task automatic send_dev(input [7:0] d);
    wr(`SSI_ADDR_TDR, d);
    wr(`SSI_ADDR_FLAGS, 8'h7F);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rdc(`SSI_ADDR_FLAGS, 8'h84);
    rdc(`SSI_ADDR_BRR, 8'hFF);
    rdc(`SSI_ADDR_CMS, 8'h00);
    rdc(32'hFFFFFE90, 8'h00);
    port_direction_bit <= 1'b1;
    wr(`SSI_ADDR_BRR, 8'h00);
    wr(`SSI_ADDR_MODE, 8'h28);
    wr(`SSI_ADDR_CMS, 8'h01);
    wr(`SSI_ADDR_CTRL, 8'h20);
    send_dev(8'h3B);
    repeat (11 * ETU + ETU / 2) @(posedge ref_clk);
    rdc(`SSI_ADDR_FLAGS, 8'h80);
    wait_flag(`SSI_FLG_TRANSMIT_END_FLAG);
    `CHECK(card.rx_bits, 9'h13B)
    err_req <= 1'b1;
    send_dev(8'h5A);
    repeat (12 * ETU) @(posedge ref_clk);
    rdc(`SSI_ADDR_FLAGS, 8'h90);
    err_req <= 1'b0;
    wr(`SSI_ADDR_FLAGS, 8'hEF);
    wait_flag(`SSI_FLG_TRANSMIT_END_FLAG);
    `CHECK(card.rx_bits, 9'h05A)
    `CHECK(card.n_frames, 3)
    wr(`SSI_ADDR_MODE, 8'hB8);
    wr(`SSI_ADDR_CMS, 8'h0D);
    send_dev(8'h3F);
    // Read past the 1 etu end point, well before the 2.5 etu one
    repeat (11 * ETU + 3 * ETU / 4) @(posedge ref_clk);
    rdc(`SSI_ADDR_FLAGS, 8'h84);
    `CHECK(card.rx_bits, 9'h103)
    repeat (2 * ETU) @(posedge ref_clk);
    wr(`SSI_ADDR_CTRL, 8'h10);
    wr(`SSI_ADDR_MODE, 8'h28);
    wr(`SSI_ADDR_CMS, 8'h01);
    card.send(9'h13B);
    rdc(`SSI_ADDR_RDR, 8'h3B);
    rdc(`SSI_ADDR_FLAGS, 8'hC4);
    `CHECK(card.err_seen, 1'b0)
    wr(`SSI_ADDR_FLAGS, 8'hBF);
    card.send(9'h03B);
    `CHECK(card.err_seen, 1'b1)
    rdc(`SSI_ADDR_FLAGS, 8'h8C);
    // Closed loop: the receiver hears the device's own inverse frame
    wr(`SSI_ADDR_MODE, 8'hB8);
    wr(`SSI_ADDR_CMS, 8'h0D);
    wr(`SSI_ADDR_CTRL, 8'h30);
    send_dev(8'hC1);
    wait_flag(`SSI_FLG_RX_FULL_FLAG);
    rdc(`SSI_ADDR_RDR, 8'hC1);
    wait_flag(`SSI_FLG_TRANSMIT_END_FLAG);
    wr(`SSI_ADDR_CTRL, 8'h11);
    repeat (4) @(posedge ref_clk);
    `CHECK(card_clk_oe_r, 1'b1)
    // Half period is 4^n*(N+1) clocks: n=1, N=0 gives 16 flips in 64
    wr(`SSI_ADDR_MODE, 8'h29);
    repeat (8) @(posedge ref_clk);
    clk_was = card_clk_out_r;
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      if (card_clk_out_r !== clk_was) n_edges++;
      clk_was = card_clk_out_r;
    end
    `CHECK(n_edges, 16)
    // Stop the clock first: a shorter divide would stretch one half
    wr(`SSI_ADDR_CTRL, 8'h10);
    wr(`SSI_ADDR_MODE, 8'hA8);
    wr(`SSI_ADDR_CTRL, 8'h12);
    repeat (2) @(posedge ref_clk);
    `CHECK(card_clk_out_r, 1'b1)
    wr(`SSI_ADDR_CMS, 8'h00);
    repeat (2) @(posedge ref_clk);
    `CHECK({card_clk_oe_r, card_clk_out_r}, 2'b10)
    wrap_up();
  end
endmodule
